// *** test/lcd_driver_host_interface_tb_top.sv ***
`default_nettype none
module lcd_driver_host_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_if_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic       d82;
    logic [6:0] col;
    logic [6:0] row;
    logic [8:0] segment_output;
    logic       sv;
    logic [6:0] common_output;
    logic       cv;
  } row_t;
  localparam row_t TBL [8] = '{
    '{1'b0, 7'h00, 7'h00, 9'h00A, 1'b1, 7'h08, 1'b1},
    '{1'b0, 7'h61, 7'h21, 9'h12D, 1'b1, 7'h29, 1'b1},
    '{1'b0, 7'h62, 7'h22, 9'h000, 1'b0, 7'h32, 1'b1},
    '{1'b0, 7'h00, 7'h42, 9'h00A, 1'b1, 7'h52, 1'b1},
    '{1'b0, 7'h00, 7'h43, 9'h00A, 1'b1, 7'h00, 1'b0},
    '{1'b1, 7'h00, 7'h00, 9'h001, 1'b1, 7'h01, 1'b1},
    '{1'b1, 7'h67, 7'h51, 9'h136, 1'b1, 7'h52, 1'b1},
    '{1'b1, 7'h68, 7'h52, 9'h000, 1'b0, 7'h00, 1'b0}};
  logic       clock_in                 = 1'b0;
  logic       sys_rst_in               = 1'b1;
  logic       interface_type_select_in = 1'b0;
  logic       parallel_style_select_in = 1'b1;
  logic       serial_width_select_in   = 1'b0;
  logic       clock_source_select_in   = 1'b0;
  logic       external_timing_clock_in = 1'b0;
  logic       oscillator_clock_in      = 1'b0;
  logic [7:0] mem_read_data_in         = 8'h40;
  logic       duty_82_in               = 1'b0;
  logic [6:0] column_in                = 7'h00;
  logic [6:0] row_in                   = 7'h00;
  wire  logic chip_select_n_in;
  wire  logic serial_clock_in;
  wire  logic serial_data_pin_in;
  wire  logic data_command_select_in;
  wire  logic read_strobe_in;
  wire  logic write_strobe_in;
  wire  logic [7:0] bus_data_in;
  logic [7:0] bus_data_out;
  logic       bus_data_oe_out;
  logic       unit_valid_out;
  unit_t      unit_out;
  logic       mem_write_out;
  logic [7:0] mem_write_data_out;
  logic       mem_read_req_out;
  logic       timing_tick_out;
  logic [8:0] segment_first_out;
  logic       segment_valid_out;
  logic [6:0] common_index_out;
  logic       common_valid_out;
  int         failures = 0;
  int         n_tests  = 0;
  int         n_units  = 0;
  int         n_wr     = 0;
  int         n_ticks  = 0;
  int         n_ser_rd = 0;
  unit_t      last_unit;
  logic [7:0] last_wd;
  logic [7:0] q;

  always #25 clock_in = ~clock_in;

  lcd_host_if uut (.*);

  lcd_host_model h (
    .clock_in (clock_in),
    .style_in (parallel_style_select_in),
    .oe_in    (bus_data_oe_out),
    .bus_in   (bus_data_out),
    .cs_n_out (chip_select_n_in),
    .scl_out  (serial_clock_in),
    .sio_out  (serial_data_pin_in),
    .dc_out   (data_command_select_in),
    .rd_out   (read_strobe_in),
    .wr_out   (write_strobe_in),
    .bus_out  (bus_data_in)
  );

  // ------------------------------------------------------------
  // monitors and memory stand-in
  // ------------------------------------------------------------
  always @(posedge clock_in) begin
    if (unit_valid_out) begin
      n_units++;
      last_unit = unit_out;
    end
    if (mem_write_out) begin
      n_wr++;
      last_wd = mem_write_data_out;
    end
    if (timing_tick_out) n_ticks++;
    if (!interface_type_select_in && (bus_data_oe_out || mem_read_req_out))
      n_ser_rd++;
    if (mem_read_req_out) mem_read_data_in <= mem_read_data_in + 8'h01;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("BAD %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic pulses(input int ne, input int no);
    for (int i = 0; i < 7; i++) begin
      external_timing_clock_in <= (i < ne);
      oscillator_clock_in      <= (i < no);
      repeat (4) @(posedge clock_in);
      external_timing_clock_in <= 1'b0;
      oscillator_clock_in      <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
    repeat (6) @(posedge clock_in);
  endtask : pulses

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    $display("BAD %0t run did not finish", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_in);
    chk_val({2'b00, bus_data_out}, 10'h000);
    chk_val({6'h00, unit_valid_out, mem_write_out, bus_data_oe_out,
             mem_read_req_out}, 10'h000);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    $display("test reset done");
    foreach (TBL[i]) begin
      duty_82_in <= TBL[i].d82;
      column_in  <= TBL[i].col;
      row_in     <= TBL[i].row;
      repeat (2) @(posedge clock_in);
      chk_val({segment_valid_out, segment_first_out & {9{TBL[i].sv}}},
              {TBL[i].sv, TBL[i].segment_output});
      chk_val({common_valid_out, 2'b00, common_index_out & {7{TBL[i].cv}}},
              {TBL[i].cv, 2'b00, TBL[i].common_output});
    end
    $display("test duty table done");
    h.ser(1'b1, 1'b0, 8'h25, 9, 1'b1);
    chk_val({1'b0, last_unit.is_data, last_unit.payload}, 10'h025);
    h.ser(1'b1, 1'b1, 8'h11, 9, 1'b1);
    chk_val(last_unit, 10'h311);
    h.ser(1'b1, 1'b1, 8'h12, 9, 1'b1);
    chk_val(last_unit, 10'h212);
    h.ser(1'b1, 1'b0, 8'h26, 9, 1'b1);
    h.ser(1'b1, 1'b1, 8'h77, 5, 1'b1);
    h.ser(1'b1, 1'b1, 8'h13, 9, 1'b1);
    chk_val(last_unit, 10'h313);
    chk_cnt(n_units, 5);
    h.ser(1'b1, 1'b1, 8'h55, 9, 1'b0);
    chk_cnt(n_units, 5);
    h.ser(1'b1, 1'b0, MEM_READ_CMD, 9, 1'b1);
    serial_width_select_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    h.ser(1'b0, 1'b0, 8'hA7, 8, 1'b1);
    chk_val({1'b0, last_unit.is_data, last_unit.payload}, 10'h0A7);
    h.ser(1'b0, 1'b1, 8'h3C, 8, 1'b1);
    chk_val(last_unit, 10'h33C);
    chk_cnt(n_ser_rd, 0);
    $display("test serial done");
    interface_type_select_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    h.acc(1'b0, 1'b1, 8'h99, q);
    chk_cnt(n_wr, 0);
    h.acc(1'b0, 1'b0, MEM_WRITE_CMD, q);
    h.acc(1'b0, 1'b1, 8'h5A, q);
    chk_val({n_wr[1:0], last_wd}, 10'h15A);
    parallel_style_select_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    h.acc(1'b0, 1'b1, 8'hC3, q);
    chk_val({n_wr[1:0], last_wd}, 10'h2C3);
    h.acc(1'b0, 1'b0, MEM_READ_CMD, q);
    h.acc(1'b1, 1'b1, 8'h00, q);
    chk_val({2'b00, q}, {2'b00, DUMMY_READ_VALUE});
    parallel_style_select_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    // host drops the dummy, keeps the second read
    h.acc(1'b1, 1'b1, 8'h00, q);
    chk_val({2'b00, q}, 10'h040);
    $display("test parallel done");
    n_ticks = 0;
    pulses(5, 7);
    chk_cnt(n_ticks, 5);
    clock_source_select_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    n_ticks = 0;
    pulses(5, 7);
    chk_cnt(n_ticks, 7);
    $display("test clock select done");
    finish_test();
  end
endmodule : lcd_driver_host_interface_tb_top
`default_nettype wire

// *** test/lcd_host_model.sv ***
`default_nettype none
module lcd_host_model (
  input  wire logic       clock_in,
  input  wire logic       style_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] bus_in,
  output logic            cs_n_out,
  output logic            scl_out,
  output logic            sio_out,
  output logic            dc_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic      [7:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic rd_act = 1'b0;
  logic wr_act = 1'b0;
  logic dir    = 1'b0;

  initial begin
    cs_n_out = 1'b1;
    scl_out  = 1'b1;
    sio_out  = 1'b0;
    dc_out   = 1'b0;
    bus_out  = 8'h00;
  end

  // ------------------------------------------------------------
  // parallel strobes
  // ------------------------------------------------------------
  // strobes or enable
  assign rd_out = style_in ? ~rd_act : rd_act;
  assign wr_out = style_in ? ~wr_act : dir;

  // ------------------------------------------------------------
  // serial link, clock idles high outside frames
  // ------------------------------------------------------------
  task automatic ser(input logic nine, input logic dc, input logic [7:0] d,
                     input int nbits, input logic sel);
    logic [8:0] v;
    v = nine ? {dc, d} : {d, 1'b0};
    cs_n_out <= ~sel;
    dc_out   <= dc;
    repeat (4) @(posedge clock_in);
    for (int i = 0; i < nbits; i++) begin
      scl_out <= 1'b0;
      sio_out <= v[8-i];
      repeat (4) @(posedge clock_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clock_in);
    end
    cs_n_out <= 1'b1;
    sio_out  <= ~sio_out;
    dc_out   <= ~dc;
    repeat (6) @(posedge clock_in);
  endtask : ser

  // ------------------------------------------------------------
  // parallel access, read value only while device drives bus
  // ------------------------------------------------------------
  task automatic acc(input logic rd, input logic dc, input logic [7:0] d,
                     output logic [7:0] q);
    cs_n_out <= 1'b0;
    dc_out   <= dc;
    bus_out  <= d;
    dir      <= rd;
    repeat (2) @(posedge clock_in);
    if (style_in && !rd) begin
      wr_act <= 1'b1;
    end else begin
      rd_act <= 1'b1;
    end
    repeat (5) @(posedge clock_in);
    q = oe_in ? bus_in : 8'hXX;
    rd_act <= 1'b0;
    wr_act <= 1'b0;
    repeat (4) @(posedge clock_in);
    cs_n_out <= 1'b1;
    bus_out  <= ~d;
    repeat (2) @(posedge clock_in);
  endtask : acc
endmodule : lcd_host_model
`default_nettype wire

// *** verilog/lcd_host_if.sv ***
// Behaviour
// - serial link never returns display memory
// - width select high 8-bit, low 9-bit
// - 9-bit unit: flag then eight payload bits
// - 8-bit unit classified by data/command pin
// - data/command high data, low command
// - sample on rising clock while selected
// - deselect mid unit discards the partial unit
// - abort leaves the parameter count unchanged
// - type select low serial, high parallel
// - style high strobes, low enable plus direction
// - parallel memory access needs no waits
// - written data follows memory write command
// - first read after read command is dummy
// - clock select low external, high oscillator
// - 1/67 duty: columns 0-97 to segments 10-303
// - 1/82 duty: columns 0-103 to segments 1-312
// - 1/67 duty: commons 8-41 and 50-82 valid
// - 1/82 duty: commons 1-82 all valid
`default_nettype none
module lcd_host_if (
  input  wire logic                   clock_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   interface_type_select_in,
  input  wire logic                   parallel_style_select_in,
  input  wire logic                   serial_width_select_in,
  input  wire logic                   clock_source_select_in,
  input  wire logic                   external_timing_clock_in,
  input  wire logic                   oscillator_clock_in,
  input  wire logic                   chip_select_n_in,
  input  wire logic                   serial_clock_in,
  input  wire logic                   serial_data_pin_in,
  input  wire logic                   data_command_select_in,
  input  wire logic                   read_strobe_in,
  input  wire logic                   write_strobe_in,
  input  wire logic [7:0]             bus_data_in,
  output logic      [7:0]             bus_data_out,
  output logic                        bus_data_oe_out,
  output logic                        unit_valid_out,
  output lcd_if_pkg::unit_t           unit_out,
  output logic                        mem_write_out,
  output logic      [7:0]             mem_write_data_out,
  output logic                        mem_read_req_out,
  input  wire logic [7:0]             mem_read_data_in,
  output logic                        timing_tick_out,
  input  wire logic                   duty_82_in,
  input  wire logic [6:0]             column_in,
  input  wire logic [6:0]             row_in,
  output logic      [8:0]             segment_first_out,
  output logic                        segment_valid_out,
  output logic      [6:0]             common_index_out,
  output logic                        common_valid_out
);
  import lcd_if_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  pins_t raw;
  pins_t pin;
  pins_t prev;

  assign raw = '{iface_par: interface_type_select_in,
                 style80:   parallel_style_select_in,
                 width8:    serial_width_select_in,
                 clk_sel:   clock_source_select_in,
                 ext_clk:   external_timing_clock_in,
                 osc_clk:   oscillator_clock_in,
                 cs_n:      chip_select_n_in,
                 scl:       serial_clock_in,
                 serial_data_pin:       serial_data_pin_in,
                 dc:        data_command_select_in,
                 rd:        read_strobe_in,
                 wr:        write_strobe_in,
                 bus:       bus_data_in};

  pin_sync #(.WIDTH($bits(pins_t))) u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (raw),
    .sync_out   (pin)
  );

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prev <= '0;
    end else begin
      prev <= pin;
    end
  end

  logic ser_mode;
  logic par_sel;
  logic scl_rise;
  logic cs_rise;
  logic ext_rise;
  logic osc_rise;
  logic read_active;
  logic read_done;
  logic write_done;

  assign ser_mode = !pin.iface_par;
  assign par_sel  = pin.iface_par && !pin.cs_n;
  assign scl_rise = pin.scl && !prev.scl;
  assign cs_rise  = pin.cs_n && !prev.cs_n;
  assign ext_rise = pin.ext_clk && !prev.ext_clk;
  assign osc_rise = pin.osc_clk && !prev.osc_clk;

  // strobe style decode: rd/wr are active low in
  // strobe style; in enable style rd is the enable, wr the direction
  always_comb begin
    if (pin.style80) begin
      read_active = par_sel && !pin.rd;
      read_done   = par_sel && pin.rd && !prev.rd;
      write_done  = par_sel && pin.wr && !prev.wr;
    end else begin
      read_active = par_sel && pin.rd && pin.wr;
      read_done   = par_sel && !pin.rd && prev.rd && pin.wr;
      write_done  = par_sel && !pin.rd && prev.rd && !pin.wr;
    end
  end

  // ----------------------------------------------------------------
  // serial receiver
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [8:0] shift, next_shift;
  logic [3:0] unit_len;
  logic       ser_emit;
  logic       ser_is_data;

  assign unit_len = pin.width8 ? UNIT_BITS_NARROW : UNIT_BITS_WIDE;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    ser_emit     = 1'b0;
    ser_is_data  = 1'b0;
    if (!ser_mode || pin.cs_n) begin
      next_bit_cnt = 4'h0;
    end else if (scl_rise) begin
      // shift on rising clock while selected
      next_shift = {shift[7:0], pin.serial_data_pin};
      if (bit_cnt == unit_len - 4'h1) begin
        ser_emit     = 1'b1;
        next_bit_cnt = 4'h0;
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
    // flag bit or select pin classifies
    ser_is_data = pin.width8 ? pin.dc : next_shift[8];
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bit_cnt <= 4'h0;
      shift   <= 9'h000;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
    end
  end

  // ----------------------------------------------------------------
  // command tracking and memory access
  // ----------------------------------------------------------------
  access_mode_t mode, next_mode;
  logic [7:0]   param_cnt, next_param_cnt;
  logic [7:0]   hold, next_hold;
  logic         fetch_pending, next_fetch_pending;
  logic         next_unit_valid;
  unit_t        next_unit;
  logic         next_mem_write;
  logic         next_mem_read_req;
  logic         take;
  logic         take_data;
  logic [7:0]   take_byte;
  logic         read_cmd_go;

  assign take      = ser_emit || write_done;
  // select pin level classifies parallel writes
  assign take_data = ser_emit ? ser_is_data : pin.dc;
  assign take_byte = ser_emit ? next_shift[7:0] : pin.bus;
  assign read_cmd_go = take && !take_data && take_byte == MEM_READ_CMD;

  always_comb begin
    next_mode          = mode;
    next_param_cnt     = param_cnt;
    next_hold          = hold;
    next_fetch_pending = 1'b0;
    next_unit_valid    = 1'b0;
    next_unit          = unit_out;
    next_mem_write     = 1'b0;
    next_mem_read_req  = 1'b0;
    if (fetch_pending) begin
      next_hold = mem_read_data_in;
    end
    if (take) begin
      next_unit_valid = 1'b1;
      next_unit       = '{is_data: take_data,
                          first_param: take_data && param_cnt == 8'h00,
                          payload: take_byte};
      if (!take_data) begin
        next_param_cnt = 8'h00;
        if (take_byte == MEM_WRITE_CMD) begin
          next_mode = MODE_MEM_WRITE;
        end else if (read_cmd_go && !ser_mode) begin
          // first read shows dummy; fetch starts at its end
          next_mode = MODE_MEM_READ;
          next_hold = DUMMY_READ_VALUE;
        end else begin
          next_mode = MODE_IDLE;
        end
      end else begin
        if (param_cnt != 8'hFF) begin
          next_param_cnt = param_cnt + 8'h01;
        end
        // data after write command goes to memory
        if (mode == MODE_MEM_WRITE) begin
          next_mem_write = 1'b1;
        end
      end
    end
    // holding register refilled after each read
    if (read_done && mode == MODE_MEM_READ) begin
      next_mem_read_req  = 1'b1;
      next_fetch_pending = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mode               <= MODE_IDLE;
      param_cnt          <= 8'h00;
      hold               <= DUMMY_READ_VALUE;
      fetch_pending      <= 1'b0;
      unit_valid_out     <= 1'b0;
      unit_out           <= '0;
      mem_write_out      <= 1'b0;
      mem_write_data_out <= 8'h00;
      mem_read_req_out   <= 1'b0;
    end else begin
      mode               <= next_mode;
      param_cnt          <= next_param_cnt;
      hold               <= next_hold;
      fetch_pending      <= next_fetch_pending;
      unit_valid_out     <= next_unit_valid;
      unit_out           <= next_unit;
      mem_write_out      <= next_mem_write;
      mem_write_data_out <= next_mem_write ? take_byte : mem_write_data_out;
      mem_read_req_out   <= next_mem_read_req;
    end
  end

  // bus driven only in parallel mode during a read
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bus_data_oe_out <= 1'b0;
      bus_data_out    <= 8'h00;
    end else begin
      bus_data_oe_out <= read_active && !ser_mode;
      bus_data_out    <= hold;
    end
  end

  // ----------------------------------------------------------------
  // timing clock and duty mapping
  // ----------------------------------------------------------------
  logic       next_tick;
  logic [8:0] next_seg;
  logic       next_seg_valid;
  logic [6:0] next_com;
  logic       next_com_valid;
  logic [8:0] col_offset;

  assign col_offset = 9'(column_in) * SEG_PER_COL;

  always_comb begin
    next_tick = pin.clk_sel ? osc_rise : ext_rise;
    if (duty_82_in) begin
      next_seg       = SEG_BASE_82 + col_offset;
      next_seg_valid = column_in <= LAST_COL_82;
      next_com       = row_in + COM_BASE_82;
      next_com_valid = row_in <= LAST_ROW_82;
    end else begin
      next_seg       = SEG_BASE_67 + col_offset;
      next_seg_valid = column_in <= LAST_COL_67;
      // two common blocks around the gap
      if (row_in < SPLIT_ROW_67) begin
        next_com = row_in + COM_BASE_67;
      end else begin
        next_com = row_in + COM_GAP_67;
      end
      next_com_valid = row_in <= LAST_ROW_67;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      timing_tick_out   <= 1'b0;
      segment_first_out <= 9'h000;
      segment_valid_out <= 1'b0;
      common_index_out  <= 7'h00;
      common_valid_out  <= 1'b0;
    end else begin
      timing_tick_out   <= next_tick;
      segment_first_out <= next_seg;
      segment_valid_out <= next_seg_valid;
      common_index_out  <= next_com;
      common_valid_out  <= next_com_valid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  chk_serial_no_drive: assert property (
    $past(ser_mode) |-> !bus_data_oe_out)
    else $error("bus driven in serial mode");
  chk_unit_bit_count: assert property (
    ser_emit |-> bit_cnt == (pin.width8 ? 4'h7 : 4'h8))
    else $error("serial unit length wrong");
  chk_deselect_ignore: assert property (
    pin.cs_n |-> !ser_emit ##1 !unit_valid_out || write_done)
    else $error("unit taken while deselected");
  chk_abort_discard: assert property (
    (ser_mode && cs_rise) |=> bit_cnt == 4'h0)
    else $error("partial unit kept after deselect");
  chk_first_after_cmd: assert property (
    (unit_valid_out && !unit_out.is_data) |=> param_cnt == 8'h00)
    else $error("command did not restart parameters");
  chk_dummy_first_read: assert property (
    (read_cmd_go && !ser_mode)
      |=> hold == DUMMY_READ_VALUE && !mem_read_req_out
      ##1 hold == DUMMY_READ_VALUE)
    else $error("dummy read sequence wrong");
  chk_mem_write_follow: assert property (
    (take && take_data && mode == MODE_MEM_WRITE)
      |=> mem_write_out && mem_write_data_out == $past(take_byte))
    else $error("display data not written");
  chk_clock_select: assert property (
    timing_tick_out |-> $past(pin.clk_sel ? osc_rise : ext_rise))
    else $error("timing tick from wrong clock");
  chk_segment_map_67: assert property (
    (!$past(sys_rst_in) && !$past(duty_82_in)) |->
      segment_first_out == 9'h00A + 9'($past(column_in)) * 9'h003)
    else $error("segment map wrong at 1/67 duty");
  chk_common_map_67: assert property (
    (!$past(duty_82_in) && $past(row_in) == 7'h22)
      |-> common_index_out == 7'h32 && common_valid_out)
    else $error("common gap wrong at 1/67 duty");
  chk_common_map_82: assert property (
    ($past(duty_82_in) && $past(row_in) == 7'h51)
      |-> common_index_out == 7'h52 && common_valid_out)
    else $error("last common wrong at 1/82 duty");

endmodule : lcd_host_if
`default_nettype wire

// *** verilog/lcd_if_pkg.sv ***
`default_nettype none
package lcd_if_pkg;

  // ----------------------------------------------------------------
  // command codes and read behaviour
  // ----------------------------------------------------------------
  localparam logic [7:0] MEM_WRITE_CMD    = 8'h2C;
  localparam logic [7:0] MEM_READ_CMD     = 8'h2E;
  localparam logic [7:0] DUMMY_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // serial unit lengths
  // ----------------------------------------------------------------
  localparam logic [3:0] UNIT_BITS_WIDE   = 4'h9;
  localparam logic [3:0] UNIT_BITS_NARROW = 4'h8;

  // ----------------------------------------------------------------
  // duty mapping
  // ----------------------------------------------------------------
  localparam logic [8:0] SEG_BASE_67  = 9'h00A;
  localparam logic [8:0] SEG_BASE_82  = 9'h001;
  localparam logic [8:0] SEG_PER_COL  = 9'h003;
  localparam logic [6:0] LAST_COL_67  = 7'h61;
  localparam logic [6:0] LAST_COL_82  = 7'h67;
  localparam logic [6:0] COM_BASE_67  = 7'h08;
  localparam logic [6:0] SPLIT_ROW_67 = 7'h22;
  localparam logic [6:0] COM_GAP_67   = 7'h10;
  localparam logic [6:0] LAST_ROW_67  = 7'h42;
  localparam logic [6:0] LAST_ROW_82  = 7'h51;
  localparam logic [6:0] COM_BASE_82  = 7'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {MODE_IDLE, MODE_MEM_WRITE, MODE_MEM_READ} access_mode_t;

  typedef struct packed {
    logic       is_data;
    logic       first_param;
    logic [7:0] payload;
  } unit_t;

  typedef struct packed {
    logic       iface_par;
    logic       style80;
    logic       width8;
    logic       clk_sel;
    logic       ext_clk;
    logic       osc_clk;
    logic       cs_n;
    logic       scl;
    logic       serial_data_pin;
    logic       dc;
    logic       rd;
    logic       wr;
    logic [7:0] bus;
  } pins_t;

endpackage : lcd_if_pkg
`default_nettype wire

// *** verilog/pin_sync.sv ***
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      stage    <= '0;
      sync_out <= '0;
    end else begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule : pin_sync
`default_nettype wire
